// ---- hdl/omc_pkg.sv ----
// shared constants and types of the operating mode controller
package omc_pkg;

  // ---------------------------------------------------------------
  // mode select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_ACTIVE   = 3'h0;
  localparam logic [2:0] MODE_CPU_OFF  = 3'h1;
  localparam logic [2:0] MODE_STANDBY  = 3'h3;
  localparam logic [2:0] MODE_OFF      = 3'h4;
  localparam logic [2:0] MODE_CLK_DISP = 3'h5;
  localparam logic [2:0] MODE_SHUTDOWN = 3'h6;

  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACTIVE  = 3'b000,
    ST_SLEEP   = 3'b001,
    ST_WAKE    = 3'b010,
    ST_SERVICE = 3'b011,
    ST_DEEP    = 3'b100,
    ST_RESTART = 3'b101
  } omc_state_t;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ           = 25;
  localparam int WAKE_STANDBY_US   = 10;
  localparam int WAKE_DEEP_US      = 150;
  localparam int WAKE_STANDBY_CYC  = WAKE_STANDBY_US * CLK_MHZ;
  localparam int WAKE_DEEP_CYC     = WAKE_DEEP_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // enable vector bit positions
  // ---------------------------------------------------------------
  localparam int EN_MCLK = 0;
  localparam int EN_HF   = 1;
  localparam int EN_LF   = 2;
  localparam int EN_FRAM = 3;
  localparam int EN_RAM  = 4;
  localparam int EN_CORE = 5;
  localparam int EN_BKP  = 6;
  localparam int EN_HOLD = 7;
  localparam int EN_W    = 8;

  localparam logic [EN_W-1:0] EN_RESET = 8'h7F;

  // ---------------------------------------------------------------
  // backup storage
  // ---------------------------------------------------------------
  localparam int BKP_BYTES = 32;
  localparam int BKP_AW    = 5;
  localparam int BKP_DW    = 8;

endpackage : omc_pkg

// ---- hdl/omc_backup_mem.sv ----
// retained backup storage with registered read data
`timescale 1ns/100ps
module omc_backup_mem #(
  parameter int DEPTH = omc_pkg::BKP_BYTES,
  parameter int AW    = omc_pkg::BKP_AW,
  parameter int DW    = omc_pkg::BKP_DW
) (
  input  wire logic          clk_i,
  input  wire logic          srst_i,
  input  wire logic          clear_i,
  input  wire logic          wr_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o
);

  generate
    if (DEPTH > (2 ** AW) || DEPTH < 1) begin : g_bad_depth
      $error("backup depth does not fit the address width");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0]            rdata;
  } omc_mem_reg_t;

  omc_mem_reg_t r;
  omc_mem_reg_t next_r;

  // ---------------------------------------------------------------
  // storage update
  // ---------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (clear_i) begin
      next_r.mem = '0;
    end else if (wr_i && (int'(addr_i) < DEPTH)) begin
      next_r.mem[addr_i] = wdata_i;
    end
    if (int'(addr_i) < DEPTH) begin
      next_r.rdata = r.mem[addr_i];
    end else begin
      next_r.rdata = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdata_o = r.rdata;

endmodule : omc_backup_mem

// ---- hdl/omc_mode_ctrl.sv ----
// operating mode controller: mode sequencing, gating, backup storage
//
// Function
// - one active state, software-selected low-power states
// - any interrupt wakes cpu-off and standby states
// - handler return re-enters the previous low-power state unless stay_active_i is set
// - deep states switch off core supply
// - one 32-byte backup register, peripheral space
`timescale 1ns/100ps
module omc_mode_ctrl #(
  parameter int CNT_W = 12
) (
  input  wire logic                        clk_i,
  input  wire logic                        srst_i,
  input  wire logic                        sleep_req_i,
  input  wire logic [2:0]                  mode_sel_i,
  input  wire logic                        irq_i,
  input  wire logic                        reti_i,
  input  wire logic                        stay_active_i,
  input  wire logic                        io_wake_i,
  input  wire logic                        rtc_wake_i,
  input  wire logic                        bkp_wr_i,
  input  wire logic [omc_pkg::BKP_AW-1:0]  bkp_addr_i,
  input  wire logic [omc_pkg::BKP_DW-1:0]  bkp_wdata_i,
  output logic      [omc_pkg::BKP_DW-1:0]  bkp_rdata_o,
  output logic      [2:0]                  mode_o,
  output logic                             cpu_run_o,
  output logic                             mclk_en_o,
  output logic                             hf_clk_en_o,
  output logic                             lf_clk_en_o,
  output logic                             fram_en_o,
  output logic                             ram_en_o,
  output logic                             core_pwr_en_o,
  output logic                             bkp_pwr_en_o,
  output logic                             io_hold_o,
  output logic                             wake_o,
  output logic                             boot_o
);

  generate
    if (omc_pkg::WAKE_DEEP_CYC > (2 ** CNT_W) ||
        omc_pkg::WAKE_STANDBY_CYC > (2 ** CNT_W)) begin : g_bad_cnt
      $error("wake counter too narrow");
    end
  endgenerate

  typedef struct packed {
    omc_pkg::omc_state_t     st;
    logic [2:0]              mode;
    logic [CNT_W-1:0]        cnt;
    logic [omc_pkg::EN_W-1:0] en;
    logic                    wake;
    logic                    boot;
    logic                    io_s1;
    logic                    io_s2;
    logic                    rtc_s1;
    logic                    rtc_s2;
  } omc_reg_t;

  omc_reg_t r;
  omc_reg_t next_r;

  // ---------------------------------------------------------------
  // mode decode helpers
  // ---------------------------------------------------------------
  function automatic logic omc_mode_ok(input logic [2:0] m);
    case (m)
      omc_pkg::MODE_CPU_OFF,
      omc_pkg::MODE_STANDBY,
      omc_pkg::MODE_OFF,
      omc_pkg::MODE_CLK_DISP,
      omc_pkg::MODE_SHUTDOWN: omc_mode_ok = 1'b1;
      default:                omc_mode_ok = 1'b0;
    endcase
  endfunction : omc_mode_ok

  function automatic logic omc_is_deep(input logic [2:0] m);
    omc_is_deep = (m == omc_pkg::MODE_CLK_DISP) ||
                  (m == omc_pkg::MODE_SHUTDOWN);
  endfunction : omc_is_deep

  function automatic logic omc_wake_ok(input logic [2:0] m,
                                       input logic       irq,
                                       input logic       io,
                                       input logic       rtc);
    case (m)
      omc_pkg::MODE_CPU_OFF,
      omc_pkg::MODE_STANDBY:  omc_wake_ok = irq | io | rtc;
      omc_pkg::MODE_OFF,
      omc_pkg::MODE_SHUTDOWN: omc_wake_ok = io;
      omc_pkg::MODE_CLK_DISP: omc_wake_ok = io | rtc;
      default:                omc_wake_ok = 1'b0;
    endcase
  endfunction : omc_wake_ok

  function automatic logic [omc_pkg::EN_W-1:0] omc_mode_en(
      input logic [2:0] m);
    logic [omc_pkg::EN_W-1:0] e;
    e = '0;
    case (m)
      omc_pkg::MODE_ACTIVE: begin
        e = omc_pkg::EN_RESET;
      end
      omc_pkg::MODE_CPU_OFF: begin
        e[omc_pkg::EN_HF]   = 1'b1;
        e[omc_pkg::EN_LF]   = 1'b1;
        e[omc_pkg::EN_FRAM] = 1'b1;
        e[omc_pkg::EN_RAM]  = 1'b1;
        e[omc_pkg::EN_CORE] = 1'b1;
        e[omc_pkg::EN_BKP]  = 1'b1;
      end
      omc_pkg::MODE_STANDBY: begin
        e[omc_pkg::EN_LF]   = 1'b1;
        e[omc_pkg::EN_RAM]  = 1'b1;
        e[omc_pkg::EN_CORE] = 1'b1;
        e[omc_pkg::EN_BKP]  = 1'b1;
        e[omc_pkg::EN_HOLD] = 1'b1;
      end
      omc_pkg::MODE_OFF: begin
        e[omc_pkg::EN_RAM]  = 1'b1;
        e[omc_pkg::EN_CORE] = 1'b1;
        e[omc_pkg::EN_BKP]  = 1'b1;
        e[omc_pkg::EN_HOLD] = 1'b1;
      end
      omc_pkg::MODE_CLK_DISP: begin
        e[omc_pkg::EN_LF]   = 1'b1;
        e[omc_pkg::EN_BKP]  = 1'b1;
        e[omc_pkg::EN_HOLD] = 1'b1;
      end
      omc_pkg::MODE_SHUTDOWN: begin
        e[omc_pkg::EN_HOLD] = 1'b1;
      end
      default: begin
        e = omc_pkg::EN_RESET;
      end
    endcase
    omc_mode_en = e;
  endfunction : omc_mode_en

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  logic wake_ev;
  logic sleep_go;

  assign wake_ev  = omc_wake_ok(r.mode, irq_i, r.io_s2, r.rtc_s2);
  assign sleep_go = sleep_req_i && omc_mode_ok(mode_sel_i);

  always_comb begin
    next_r        = r;
    next_r.io_s1  = io_wake_i;
    next_r.io_s2  = r.io_s1;
    next_r.rtc_s1 = rtc_wake_i;
    next_r.rtc_s2 = r.rtc_s1;
    next_r.wake   = 1'b0;
    next_r.boot   = 1'b0;
    case (r.st)
      omc_pkg::ST_ACTIVE: begin
        next_r.mode = omc_pkg::MODE_ACTIVE;
        next_r.en   = omc_mode_en(omc_pkg::MODE_ACTIVE);
        if (sleep_go) begin
          next_r.mode = mode_sel_i;
          next_r.en   = omc_mode_en(mode_sel_i);
          if (omc_is_deep(mode_sel_i)) begin
            next_r.st = omc_pkg::ST_DEEP;
          end else begin
            next_r.st = omc_pkg::ST_SLEEP;
          end
        end
      end
      omc_pkg::ST_SLEEP: begin
        if (wake_ev) begin
          if (r.mode == omc_pkg::MODE_CPU_OFF) begin
            next_r.st   = omc_pkg::ST_SERVICE;
            next_r.en   = omc_mode_en(omc_pkg::MODE_ACTIVE);
            next_r.wake = 1'b1;
          end else begin
            next_r.st  = omc_pkg::ST_WAKE;
            next_r.cnt = CNT_W'(omc_pkg::WAKE_STANDBY_CYC - 1);
            next_r.en  = omc_mode_en(omc_pkg::MODE_CPU_OFF);
          end
        end
      end
      omc_pkg::ST_WAKE: begin
        if (r.cnt == '0) begin
          next_r.st   = omc_pkg::ST_SERVICE;
          next_r.en   = omc_mode_en(omc_pkg::MODE_ACTIVE);
          next_r.wake = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      omc_pkg::ST_SERVICE: begin
        if (reti_i) begin
          if (stay_active_i) begin
            next_r.st   = omc_pkg::ST_ACTIVE;
            next_r.mode = omc_pkg::MODE_ACTIVE;
          end else begin
            next_r.st = omc_pkg::ST_SLEEP;
            next_r.en = omc_mode_en(r.mode);
          end
        end
      end
      omc_pkg::ST_DEEP: begin
        if (wake_ev) begin
          next_r.st  = omc_pkg::ST_RESTART;
          next_r.cnt = CNT_W'(omc_pkg::WAKE_DEEP_CYC - 1);
          next_r.en  = omc_mode_en(omc_pkg::MODE_OFF);
        end
      end
      omc_pkg::ST_RESTART: begin
        if (r.cnt == '0) begin
          next_r.st   = omc_pkg::ST_ACTIVE;
          next_r.mode = omc_pkg::MODE_ACTIVE;
          next_r.en   = omc_mode_en(omc_pkg::MODE_ACTIVE);
          next_r.boot = 1'b1;
        end else begin
          next_r.cnt = r.cnt - 1'b1;
        end
      end
      default: begin
        next_r.st   = omc_pkg::ST_ACTIVE;
        next_r.mode = omc_pkg::MODE_ACTIVE;
        next_r.en   = omc_pkg::EN_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r      <= '0;
      r.st   <= omc_pkg::ST_ACTIVE;
      r.mode <= omc_pkg::MODE_ACTIVE;
      r.en   <= omc_pkg::EN_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // backup storage
  // ---------------------------------------------------------------
  logic bkp_clear;
  logic bkp_wr;

  assign bkp_clear = !r.en[omc_pkg::EN_BKP];
  assign bkp_wr    = bkp_wr_i && r.en[omc_pkg::EN_MCLK];

  omc_backup_mem #(
    .DEPTH (omc_pkg::BKP_BYTES),
    .AW    (omc_pkg::BKP_AW),
    .DW    (omc_pkg::BKP_DW)
  ) u_bkp (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .clear_i (bkp_clear),
    .wr_i    (bkp_wr),
    .addr_i  (bkp_addr_i),
    .wdata_i (bkp_wdata_i),
    .rdata_o (bkp_rdata_o)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign mode_o        = r.mode;
  assign cpu_run_o     = r.en[omc_pkg::EN_MCLK];
  assign mclk_en_o     = r.en[omc_pkg::EN_MCLK];
  assign hf_clk_en_o   = r.en[omc_pkg::EN_HF];
  assign lf_clk_en_o   = r.en[omc_pkg::EN_LF];
  assign fram_en_o     = r.en[omc_pkg::EN_FRAM];
  assign ram_en_o      = r.en[omc_pkg::EN_RAM];
  assign core_pwr_en_o = r.en[omc_pkg::EN_CORE];
  assign bkp_pwr_en_o  = r.en[omc_pkg::EN_BKP];
  assign io_hold_o     = r.en[omc_pkg::EN_HOLD];
  assign wake_o        = r.wake;
  assign boot_o        = r.boot;

endmodule : omc_mode_ctrl

// ---- tb/omc_checker.sv ----
// assertions on the ports of the operating mode controller
`timescale 1ns/100ps
module omc_checker (
  input wire logic       clk_i,
  input wire logic       srst_i,
  input wire logic       sleep_req_i,
  input wire logic [2:0] mode_sel_i,
  input wire logic       irq_i,
  input wire logic       reti_i,
  input wire logic       stay_active_i,
  input wire logic       bkp_wr_i,
  input wire logic [4:0] bkp_addr_i,
  input wire logic [7:0] bkp_wdata_i,
  input wire logic [7:0] bkp_rdata_o,
  input wire logic [2:0] mode_o,
  input wire logic       cpu_run_o,
  input wire logic       mclk_en_o,
  input wire logic       hf_clk_en_o,
  input wire logic       core_pwr_en_o,
  input wire logic       bkp_pwr_en_o,
  input wire logic       io_hold_o,
  input wire logic       wake_o,
  input wire logic       boot_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic        act;
  logic [11:0] ramp;
  assign act = cpu_run_o && mode_o == 3'h0;
  // cycles with core powered and cpu held off
  always_ff @(posedge clk_i) begin
    if (srst_i || cpu_run_o || !core_pwr_en_o) begin
      ramp <= 12'h000;
    end else begin
      ramp <= ramp + 12'h001;
    end
  end
  sequence s_wr;
    bkp_wr_i && cpu_run_o ##1 !bkp_wr_i && $stable(bkp_addr_i);
  endsequence
  sequence s_ramp;
    hf_clk_en_o && !cpu_run_o ##250 wake_o && cpu_run_o;
  endsequence
  a_enter_standby: assert property (
    act && sleep_req_i && mode_sel_i == 3'h3 |=> mode_o == 3'h3
    && !mclk_en_o && io_hold_o) else $error("bad standby entry");
  a_bad_code: assert property (
    act && sleep_req_i && mode_sel_i inside {3'h0, 3'h2, 3'h7} |=> act)
    else $error("bad code acted on");
  a_cpuoff_wake: assert property (
    mode_o == 3'h1 && !cpu_run_o && irq_i |=> wake_o && cpu_run_o)
    else $error("no cpu-off wake");
  a_standby_wake: assert property (
    mode_o == 3'h3 && !hf_clk_en_o && irq_i |=> s_ramp)
    else $error("bad standby wake");
  a_deep_core_off: assert property (
    act && sleep_req_i && mode_sel_i inside {3'h5, 3'h6} |=> !core_pwr_en_o
    && bkp_pwr_en_o == (mode_o == 3'h5)) else $error("core not off");
  a_boot_time: assert property (
    boot_o |-> ramp == 12'hEA6 && cpu_run_o) else $error("bad boot time");
  a_return_sleep: assert property (
    cpu_run_o && mode_o != 3'h0 && reti_i && !stay_active_i
    |=> !cpu_run_o && mode_o == $past(mode_o)) else $error("no re-sleep");
  a_return_active: assert property (
    cpu_run_o && mode_o != 3'h0 && reti_i && stay_active_i |=> act)
    else $error("no return to active");
  a_bkp_data: assert property (
    s_wr |=> bkp_rdata_o == $past(bkp_wdata_i, 2)) else $error("bad read");
  a_bkp_clear: assert property (
    !bkp_pwr_en_o [*2] |=> bkp_rdata_o == 8'h00) else $error("not cleared");
  a_wake_pulse: assert property (
    wake_o |=> !wake_o) else $error("wake pulse too long");
endmodule : omc_checker

// ---- tb/omc_core_model.sv ----
// core and interrupt source model: raises irq, returns from handler
`timescale 1ns/100ps
module omc_core_model (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       fire_i,
  input  wire logic [3:0] delay_i,
  input  wire logic       wake_i,
  output logic            irq_o,
  output logic            reti_o
);
  logic [3:0] cnt;
  logic       busy;
  always_ff @(posedge clk_i) begin
    reti_o <= 1'b0;
    if (srst_i) begin
      irq_o <= 1'b0;
      busy  <= 1'b0;
      cnt   <= 4'h0;
    end else if (fire_i) begin
      irq_o <= 1'b1;
    end else if (wake_i) begin
      irq_o <= 1'b0;
      busy  <= 1'b1;
      cnt   <= delay_i;
    end else if (busy && cnt == 4'h0) begin
      busy   <= 1'b0;
      reti_o <= 1'b1;
    end else if (busy) begin
      cnt <= cnt - 4'h1;
    end
  end
endmodule : omc_core_model

// ---- tb/testbench.sv ----
// self-checking bench of the operating mode controller
`timescale 1ns/100ps
`define CMP(a, e) begin n_compared++; if ((a) !== (e)) begin bad_count++; \
  $display("ERROR %0t mismatch %h %h", $time, a, e); end end
module testbench;
  logic        clk_i, srst_i, sleep_req_i, stay_active_i, io_wake_i;
  logic        rtc_wake_i, bkp_wr_i, fire, irq, reti, wake_o, boot_o;
  logic        cpu_run_o, mclk_en_o, hf_clk_en_o, lf_clk_en_o, fram_en_o;
  logic        ram_en_o, core_pwr_en_o, bkp_pwr_en_o, io_hold_o;
  logic [2:0]  mode_sel_i, mode_o;
  logic [3:0]  dly;
  logic [4:0]  bkp_addr_i;
  logic [7:0]  bkp_wdata_i, bkp_rdata_o, en;
  logic [7:0]  mem [32];
  logic [2:0]  md [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6};
  logic [31:0] seed;
  int          bad_count, n_compared, i, j, s;
  assign en = {io_hold_o, bkp_pwr_en_o, core_pwr_en_o, ram_en_o, fram_en_o,
               lf_clk_en_o, hf_clk_en_o, mclk_en_o};
  always #20 clk_i = ~clk_i;
  omc_mode_ctrl u_omc_mode_ctrl (
    .clk_i, .srst_i, .sleep_req_i, .mode_sel_i, .irq_i(irq), .reti_i(reti),
    .stay_active_i, .io_wake_i, .rtc_wake_i, .bkp_wr_i, .bkp_addr_i,
    .bkp_wdata_i, .bkp_rdata_o, .mode_o, .cpu_run_o, .mclk_en_o,
    .hf_clk_en_o, .lf_clk_en_o, .fram_en_o, .ram_en_o, .core_pwr_en_o,
    .bkp_pwr_en_o, .io_hold_o, .wake_o, .boot_o);
  omc_core_model u_omc_core_model (.clk_i, .srst_i, .fire_i(fire),
    .delay_i(dly), .wake_i(wake_o), .irq_o(irq), .reti_o(reti));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  function automatic logic [7:0] exp_en(input logic [2:0] m);
    case (m)
      3'h1: return 8'h7E;
      3'h3: return 8'hF4;
      3'h4: return 8'hF0;
      3'h5: return 8'hC4;
      3'h6: return 8'h80;
      default: return 8'h7F;
    endcase
  endfunction : exp_en
  function automatic bit done(input int k);
    case (k)
      0: return wake_o === 1'b1;
      1: return boot_o === 1'b1;
      2: return cpu_run_o === 1'b0;
      default: return mode_o === 3'h0 && cpu_run_o === 1'b1;
    endcase
  endfunction : done
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  task automatic wt(input int k, input int lim);
    int n;
    for (n = 0; n < lim && !done(k); n++) @(negedge clk_i);
    if (n == lim) begin
      bad_count++;
      $display("ERROR %0t wait ran out", $time);
      conclude();
    end
  endtask : wt
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bkp_wr_i    = 1'b1;
    bkp_addr_i  = a;
    bkp_wdata_i = d;
    @(negedge clk_i);
    bkp_wr_i = 1'b0;
    @(negedge clk_i);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    bkp_addr_i = a;
    @(negedge clk_i);
    `CMP(bkp_rdata_o, e)
  endtask : rd
  task automatic enter(input logic [2:0] m);
    sleep_req_i = 1'b1;
    mode_sel_i  = m;
    @(negedge clk_i);
    sleep_req_i = 1'b0;
    `CMP(en, exp_en(m))
    `CMP(mode_o, exp_en(m) == 8'h7F ? 3'h0 : m)
    @(negedge clk_i);
  endtask : enter
  task automatic wake(input logic [2:0] m);
    seed = lfsr(seed);
    dly  = seed[3:0];
    fire = 1'b1;
    @(negedge clk_i);
    fire = 1'b0;
    if (m > 3'h3) begin
      repeat (8) @(negedge clk_i);
      `CMP(en, exp_en(m))
      io_wake_i  = (m != 3'h5);
      rtc_wake_i = (m == 3'h5);
      repeat (4) @(negedge clk_i);
      io_wake_i  = 1'b0;
      rtc_wake_i = 1'b0;
    end
  endtask : wake
  initial begin
    clk_i         = 1'b0;
    srst_i        = 1'b1;
    sleep_req_i   = 1'b0;
    stay_active_i = 1'b0;
    io_wake_i     = 1'b0;
    rtc_wake_i    = 1'b0;
    bkp_wr_i      = 1'b0;
    fire          = 1'b0;
    dly           = 4'h0;
    mode_sel_i    = 3'h0;
    bkp_addr_i    = 5'h00;
    bkp_wdata_i   = 8'h00;
    seed          = 32'hB8F9;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    `CMP(en, 8'h7F)
    for (i = 0; i < 32; i++) begin
      seed   = lfsr(seed);
      mem[i] = seed[7:0];
      wr(i[4:0], mem[i]);
    end
    for (i = 0; i < 32; i++) rd(i[4:0], mem[i]);
    enter(3'h0);
    enter(3'h2);
    enter(3'h7);
    for (i = 0; i < 5; i++) begin
      enter(md[i]);
      wr(5'h00, ~mem[0]);
      if (md[i] < 3'h5) begin
        for (s = 0; s < 2; s++) begin
          stay_active_i = s[0];
          wake(md[i]);
          wt(0, 400);
          `CMP(en, 8'h7F)
          wt(s + 2, 64);
          `CMP(en, exp_en(s ? 3'h0 : md[i]))
        end
      end else begin
        wake(md[i]);
        wt(1, 4000);
        `CMP(en, 8'h7F)
        for (j = 0; j < 32; j++) rd(j[4:0], md[i] == 3'h5 ? mem[j] : 8'h00);
      end
    end
    conclude();
  end
endmodule : testbench
bind omc_mode_ctrl omc_checker u_omc_checker (
  .clk_i, .srst_i, .sleep_req_i, .mode_sel_i, .irq_i, .reti_i,
  .stay_active_i, .bkp_wr_i, .bkp_addr_i, .bkp_wdata_i, .bkp_rdata_o,
  .mode_o, .cpu_run_o, .mclk_en_o, .hf_clk_en_o, .core_pwr_en_o,
  .bkp_pwr_en_o, .io_hold_o, .wake_o, .boot_o);
